//--- core/asi_master_scan.v
// Field-bus master scan core: slave identification, address checks, auto addressing
// and the timed polling cycle that feeds slave data to the host through a FIFO.
// Assumes the bus-side transceiver runs on clk and reports detections and replies
// as single-cycle strobes; only the supply-good level arrives from a pin.
`timescale 1ns/1ps
`include "asi_scan_consts.vh"
module asi_master_scan #(
	parameter [19:0] CYC_BASE  = `CYC_BASE_CLK,
	parameter [19:0] CYC_SLOT  = `CYC_SLOT_CLK,
	parameter [19:0] CYC_MAX31 = `CYC_MAX31_CLK,
	parameter [19:0] CYC_MAX62 = `CYC_MAX62_CLK
) (
	input  wire                 clk,
	input  wire                 rst_b,
	input  wire                 ce,
	input  wire                 power_ok_pin,
	input  wire                 auto_addr_en,
	input  wire                 flag_clr,
	input  wire                 det_valid,
	input  wire [4:0]           det_addr,
	input  wire [15:0]          det_image,
	input  wire                 resp_valid,
	input  wire [3:0]           resp_data,
	input  wire                 resp_err,
	input  wire                 pcd_wr,
	input  wire [5:0]           pcd_idx,
	input  wire [15:0]          pcd_data,
	input  wire [5:0]           cfg_idx,
	input  wire                 rx_ready,
	output reg                  poll_req,
	output reg  [5:0]           poll_idx,
	output reg                  assign_req,
	output reg  [5:0]           assign_idx,
	output reg                  addr_refused,
	output reg                  normal_operation_flag,
	output reg                  power_fail,
	output reg                  slave_fail,
	output reg                  data_error,
	output reg  [6:0]           active_count,
	output reg  [15:0]          detected_config_image,
	output reg  [15:0]          stored_config_expectation,
	output reg                  rx_valid,
	output reg  [`RX_W-1:0]     rx_data
);
	localparam [2:0] ST_START = 3'h0;
	localparam [2:0] ST_SEEK  = 3'h1;
	localparam [2:0] ST_WAIT  = 3'h2;
	localparam [2:0] ST_PUSH  = 3'h3;
	localparam [2:0] ST_HOLD  = 3'h4;

	// Entry index is {B select, address number}; entries 0 and 32 are never polled.
	reg  [15:0] cdi_mem [0:63];
	reg  [15:0] pcd_mem [0:63];
	wire [63:0] act;

	reg         pwr_meta_reg;
	reg         pwr_sync_reg;
	reg  [2:0]  state_reg;
	reg  [5:0]  scan_reg;
	reg  [19:0] timer_reg;
	reg  [7:0]  wait_reg;
	reg  [3:0]  data_reg;
	reg         phase_reg;
	reg         rm_reg;
	reg  [6:0]  cnt_next;
	reg         found;
	reg  [5:0]  found_idx;
	integer     i;
	integer     k;
	integer     j;

	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1) begin : gen_act
			if (g % 32 == 0) begin : gen_none
				assign act[g] = 1'b0;
			end else begin : gen_live
				assign act[g] = (cdi_mem[g] != `ALL_ONES);
			end
		end
	endgenerate

	always @* begin
		cnt_next = 7'h00;
		for (k = 0; k < 64; k = k + 1) begin
			cnt_next = cnt_next + {6'h00, act[k]};
		end
	end

	// Cycle length from the active count, held under the documented ceilings.
	wire [6:0]  cnt_p1    = active_count + 7'h01;
	wire [19:0] slot_mult = CYC_SLOT * {13'h0000, cnt_p1};
	wire [19:0] cyc_cap   = (active_count <= `STD_LIMIT) ? CYC_MAX31 : CYC_MAX62;
	wire [19:0] cyc_raw   = (active_count <= `SLOW_LIMIT) ? CYC_BASE : slot_mult;
	wire [19:0] cyc_len   = (cyc_raw > cyc_cap) ? cyc_cap : cyc_raw;

	// Detection decode: the image nibbles are type, I/O, function, extra ID.
	wire [3:0]  d_type  = det_image[`IMG_TYPE];
	wire        d_ab    = (d_type == `TYPE_AB);
	wire        d_b     = d_ab & det_image[`XID_B_BIT];
	wire [5:0]  d_idx   = {d_b, det_addr};
	wire [5:0]  a_idx   = {1'b0, det_addr};
	wire [5:0]  b_idx   = {1'b1, det_addr};
	wire [15:0] cur_img = cdi_mem[d_idx];
	wire [15:0] a_img   = cdi_mem[a_idx];
	wire        d_zero  = (det_addr == 5'h00);
	wire        d_rsvd  = (det_image[`IMG_IO] == `IO_RSVD);
	wire        d_clash = act[d_idx] && (cur_img[`IMG_TAG] != det_image[`IMG_TAG]);
	wire        d_b_std = d_b && act[a_idx] && (a_img[`IMG_TYPE] != `TYPE_AB);
	wire        d_s_b   = !d_ab && act[b_idx];
	// The count trails a new entry by a clock, but with only 62 usable entries the count can never pass the limit.
	wire        d_full  = !act[d_idx] && (active_count >= `MAX_SLAVES);
	wire        d_bad   = d_rsvd | d_clash | d_b_std | d_s_b | d_full;
	wire        d_take  = det_valid && !d_zero && !d_bad;

	// A removed slave is an expected entry whose slave no longer answers.
	always @* begin
		found     = 1'b0;
		found_idx = 6'h00;
		// Scanning downward lets the lowest matching entry win.
		for (j = 63; j > 0; j = j - 1) begin
			if ((j % 32 != 0) && !act[j] && (pcd_mem[j] == det_image)) begin
				found     = 1'b1;
				found_idx = j[5:0];
			end
		end
	end

	// Polling order walks address numbers upward, A before B within a number.
	wire [4:0] scan_num  = scan_reg[5:1];
	wire [5:0] scan_idx  = {scan_reg[0], scan_num};
	wire       pair_both = act[{1'b0, scan_num}] & act[{1'b1, scan_num}];
	wire       scan_skip = pair_both && (scan_reg[0] != phase_reg);
	wire       scan_hit  = act[scan_idx] && !scan_skip;
	wire       scan_end  = (scan_reg == `SCAN_LAST);
	wire       fifo_ready;
	wire       fifo_push = (state_reg == ST_PUSH);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Start out assuming a good supply, so that leaving reset raises no false
			// supply failure; a bad supply still sets power_fail three clocks later.
			pwr_meta_reg <= 1'b1;
			pwr_sync_reg <= 1'b1;
		end else if (ce) begin
			pwr_meta_reg <= power_ok_pin;
			pwr_sync_reg <= pwr_meta_reg;
		end
	end

	// Image store. Detections are absorbed in any scan state, so a slave joining
	// or being swapped never stalls the exchanges with the others.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 64; i = i + 1) begin
				cdi_mem[i] <= `ALL_ONES;
				pcd_mem[i] <= `ALL_ONES;
			end
		end else if (ce) begin
			if (pcd_wr) begin
				pcd_mem[pcd_idx] <= pcd_data;
			end
			if (rm_reg) begin
				cdi_mem[poll_idx] <= `ALL_ONES;
			end
			if (assign_req) begin
				cdi_mem[0] <= `ALL_ONES;
			end
			// Only one slave may sit at address 0, so one holding entry is enough.
			if (det_valid && d_zero) begin
				cdi_mem[0] <= det_image;
			end
			if (d_take) begin
				cdi_mem[d_idx] <= det_image;
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			assign_req   <= 1'b0;
			assign_idx   <= 6'h00;
			addr_refused <= 1'b0;
		end else if (ce) begin
			assign_req   <= det_valid && d_zero && auto_addr_en && found;
			addr_refused <= det_valid && !d_zero && d_bad;
			if (det_valid && d_zero && found) begin
				assign_idx <= found_idx;
			end
		end
	end

	// Host-facing views and status flags. A new event beats a clear in the same cycle.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			active_count              <= 7'h00;
			detected_config_image     <= `ALL_ONES;
			stored_config_expectation <= `ALL_ONES;
			power_fail                <= 1'b0;
			slave_fail                <= 1'b0;
			data_error                <= 1'b0;
		end else if (ce) begin
			active_count              <= cnt_next;
			detected_config_image     <= cdi_mem[cfg_idx];
			stored_config_expectation <= pcd_mem[cfg_idx];
			if (!pwr_sync_reg) begin
				power_fail <= 1'b1;
			end else if (flag_clr) begin
				power_fail <= 1'b0;
			end
			if (rm_reg) begin
				slave_fail <= 1'b1;
			end else if (flag_clr) begin
				slave_fail <= 1'b0;
			end
			if ((state_reg == ST_WAIT && resp_valid && resp_err) ||
				(det_valid && d_rsvd)) begin
				data_error <= 1'b1;
			end else if (flag_clr) begin
				data_error <= 1'b0;
			end
		end
	end

	// Scan sequencer. The cycle timer runs from the start of each cycle; the next
	// cycle begins only when both the walk and the timer are finished, so a
	// stalled FIFO lengthens the cycle instead of dropping slave data.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg             <= ST_START;
			scan_reg              <= `SCAN_FIRST;
			timer_reg             <= 20'h00000;
			wait_reg              <= 8'h00;
			data_reg              <= 4'h0;
			phase_reg             <= 1'b0;
			rm_reg                <= 1'b0;
			poll_req              <= 1'b0;
			poll_idx              <= 6'h00;
			normal_operation_flag <= 1'b0;
		end else if (ce) begin
			poll_req <= 1'b0;
			rm_reg   <= 1'b0;
			if (timer_reg != 20'h00000) begin
				timer_reg <= timer_reg - 20'h00001;
			end
			if (!pwr_sync_reg) begin
				normal_operation_flag <= 1'b0;
			end
			case (state_reg)
				ST_START: begin
					// The start and hold states each take a clock, so the timer is loaded two short.
					timer_reg <= cyc_len - 20'h00002;
					scan_reg  <= `SCAN_FIRST;
					state_reg <= ST_SEEK;
				end
				ST_SEEK: begin
					if (scan_hit) begin
						poll_req  <= 1'b1;
						poll_idx  <= scan_idx;
						wait_reg  <= 8'h00;
						state_reg <= ST_WAIT;
					end else if (scan_end) begin
						state_reg <= ST_HOLD;
					end else begin
						scan_reg <= scan_reg + 6'h01;
					end
				end
				ST_WAIT: begin
					wait_reg <= wait_reg + 8'h01;
					if (resp_valid && !resp_err) begin
						data_reg  <= resp_data;
						state_reg <= ST_PUSH;
					end else if (resp_valid || wait_reg == `RESP_TIMEOUT) begin
						// A silent slave is dropped from the image and flagged.
						rm_reg <= !resp_valid;
						if (scan_end) begin
							state_reg <= ST_HOLD;
						end else begin
							scan_reg  <= scan_reg + 6'h01;
							state_reg <= ST_SEEK;
						end
					end
				end
				ST_PUSH: begin
					if (fifo_ready) begin
						if (scan_end) begin
							state_reg <= ST_HOLD;
						end else begin
							scan_reg  <= scan_reg + 6'h01;
							state_reg <= ST_SEEK;
						end
					end
				end
				ST_HOLD: begin
					if (timer_reg == 20'h00000) begin
						phase_reg <= ~phase_reg;
						if (pwr_sync_reg) begin
							normal_operation_flag <= 1'b1;
						end
						state_reg <= ST_START;
					end
				end
				default: begin
					state_reg <= ST_START;
				end
			endcase
		end
	end

	// Output stage. The host sees a registered word that holds still while rx_ready is
	// low; it adds one word of buffering on top of the FIFO.
	wire             fifo_rd_valid;
	wire [`RX_W-1:0] fifo_rd_data;
	wire             fifo_rd_ready = !rx_valid || rx_ready;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_valid <= 1'b0;
			rx_data  <= {`RX_W{1'b0}};
		end else if (ce && fifo_rd_ready) begin
			rx_valid <= fifo_rd_valid;
			rx_data  <= fifo_rd_data;
		end
	end

	// Thirty-two words cover more than half a full walk, so a briefly slow host
	// costs no cycle time; a host that stops for long stretches the cycle.
	scan_fifo #(
		.W  (`RX_W),
		.D  (`FIFO_DEPTH),
		.AW (`FIFO_AW)
	) u_rx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.in_valid  (fifo_push),
		.in_ready  (fifo_ready),
		.in_data   ({poll_idx, data_reg}),
		.out_valid (fifo_rd_valid),
		.out_ready (fifo_rd_ready),
		.out_data  (fifo_rd_data)
	);
endmodule

//--- core/asi_scan_consts.vh
// Constants for the field-bus master scan core: slave image layout, address map,
// polling-cycle timing and buffer sizing.
// Assumes a 50 MHz core clock; included by the scan core only.
//
// Overview of operation
// - Standard slaves sit at 1..31; A/B slaves at 1A..31A or 1B..31B.
// - With auto addressing, a new address-0 twin takes the removed slave's address.
// - Type code 0 marks a standard remote I/O slave, Ah an A/B slave.
// - I/O allocation code gives four point roles; Fh is reserved.
// - A further nibble holds internal function, the channel number for analog slaves.
// - Extra ID nibble is free for standard slaves; its top bit picks A or B.
// - Slaves are told apart by type code together with I/O allocation code.
// - At most 31 standard slaves, or 62 when all are A/B slaves.
// - Standard slaves use A addresses only; the matching B address is refused.
// - Cycle is 3 ms up to 19 slaves, else 0.156 ms times one plus count.
// - An A and a B slave sharing a number are polled on alternate cycles.
// - Cycle stays within 5 ms for 31 slaves and 10 ms for 62; the core lets a stalled FIFO stretch it past that.
// - Supply voltage and bus data are watched; failures and data errors are flagged.
// - Adding or replacing a slave never interrupts polling of the others.
// - Configuration image is type, I/O, function, extra ID nibbles from the top.
// - Stored expectations for unused addresses hold all ones.
`ifndef ASI_SCAN_CONSTS_VH
`define ASI_SCAN_CONSTS_VH

`define ALL_ONES      16'hFFFF
`define TYPE_AB       4'hA
`define TYPE_STD      4'h0
`define IO_RSVD       4'hF
`define IMG_TYPE      15:12
`define IMG_IO        11:8
`define IMG_FUNC      7:4
`define IMG_XID       3:0
`define IMG_TAG       15:8
`define XID_B_BIT     3
`define MAX_SLAVES    7'h3E
`define SLOW_LIMIT    7'h13
`define STD_LIMIT     7'h1F
`define RESP_TIMEOUT  8'h20
`define SCAN_FIRST    6'h02
`define SCAN_LAST     6'h3F

// Cycle counts at 50 MHz: 3 ms base, 0.156 ms per slot, 5 ms and 10 ms ceilings.
`define CYC_BASE_CLK  20'h249F0
`define CYC_SLOT_CLK  20'h01E78
`define CYC_MAX31_CLK 20'h3D090
`define CYC_MAX62_CLK 20'h7A120

`define FIFO_DEPTH    32
`define FIFO_AW       5
`define RX_W          10

`endif

//--- core/scan_fifo.v
// Synchronous FIFO carrying polled slave data toward the host.
// Assumes one clock; the clock enable freezes every pointer and the storage.
`timescale 1ns/1ps
module scan_fifo #(
	parameter W  = 10,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire          clk,
	input  wire          rst_b,
	input  wire          ce,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output reg           out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0]   count_reg;
	wire         push;
	wire         pop;

	assign in_ready = (count_reg != D);
	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_reg];

	always @(posedge clk) begin
		if (ce && push) begin
			mem[wr_reg] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_reg    <= {AW{1'b0}};
			rd_reg    <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			// Valid tracks the count that results from this cycle's push and pop.
			case ({push, pop})
				2'b10: begin
					count_reg <= count_reg + 1'b1;
					out_valid <= 1'b1;
				end
				2'b01: begin
					count_reg <= count_reg - 1'b1;
					out_valid <= (count_reg != 1);
				end
				default: begin
					count_reg <= count_reg;
				end
			endcase
		end
	end
endmodule

//--- tb/asi_master_scan_assertions.sv
// Port-level checker for the scan core, bound into every instance.
// Assumes a single clock domain; the bench lowers ce only while no poll is pending.
`timescale 1ns/1ps
module asi_master_scan_assertions (
	input wire        clk,
	input wire        rst_b,
	input wire        power_ok_pin,
	input wire        auto_addr_en,
	input wire        det_valid,
	input wire [15:0] det_image,
	input wire        resp_valid,
	input wire        resp_err,
	input wire        rx_ready,
	input wire        poll_req,
	input wire [5:0]  poll_idx,
	input wire        assign_req,
	input wire        addr_refused,
	input wire        normal_operation_flag,
	input wire        power_fail,
	input wire        slave_fail,
	input wire        data_error,
	input wire [6:0]  active_count,
	input wire        rx_valid,
	input wire [9:0]  rx_data
);
	// Clocks since the last unanswered poll; it saturates so a long idle gap stays quiet.
	reg [5:0] wait_reg;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wait_reg <= 6'h00;
		else if (poll_req)
			wait_reg <= 6'h01;
		else if (resp_valid)
			wait_reg <= 6'h00;
		else if (wait_reg != 6'h00 && wait_reg != 6'h3F)
			wait_reg <= wait_reg + 6'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_IO_RSVD: assert property (
		det_valid && det_image[11:8] == 4'hF |=> addr_refused && data_error)
		else $error("reserved io code accepted");
	AST_REFUSE_CAUSE: assert property (addr_refused |-> $past(det_valid))
		else $error("refusal without a detection");
	AST_ASSIGN_EN: assert property (assign_req |-> $past(auto_addr_en))
		else $error("readdressing while auto addressing is off");
	AST_NO_ZERO_POLL: assert property (poll_req |-> poll_idx[4:0] != 5'h00)
		else $error("address zero polled");
	AST_COUNT_MAX: assert property (active_count <= 7'h3E)
		else $error("too many active slaves");
	AST_RESP_ERR: assert property (resp_valid && resp_err |=> data_error)
		else $error("corrupt reply not flagged");
	AST_TIMEOUT: assert property (wait_reg == 6'h24 |-> slave_fail)
		else $error("silent slave not flagged");
	AST_SUPPLY: assert property (
		!power_ok_pin [*5] |-> power_fail && !normal_operation_flag)
		else $error("supply loss not flagged");
	AST_RX_HOLD: assert property (
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("host word changed while stalled");
	cover property (poll_req);
	cover property (assign_req);
	cover property (addr_refused);
	cover property (rx_valid && rx_ready);
endmodule
bind asi_master_scan asi_master_scan_assertions i_asi_master_scan_assertions (.*);

//--- tb/slave_model.sv
// Reply model of the field-bus slaves behind the bus-side transceiver.
// Assumes polls arrive as one-cycle strobes; a reply follows dly+2 clocks after the poll.
`timescale 1ns/1ps
module slave_model (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       poll_req,
	input  wire [5:0] poll_idx,
	input  wire [7:0] dly,
	input  wire       mute,
	input  wire       bad,
	output reg        resp_valid,
	output reg  [3:0] resp_data,
	output reg        resp_err
);
	reg [7:0] cnt_reg;
	reg       pend_reg;
	// Idle data toggles every cycle so that a sample one clock late can never pass for a reply.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
			pend_reg <= 1'b0;
			resp_valid <= 1'b0;
			resp_data <= 4'h0;
			resp_err <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			resp_err <= 1'b0;
			resp_data <= ~resp_data;
			if (poll_req && !mute) begin
				pend_reg <= 1'b1;
				cnt_reg <= dly;
			end else if (pend_reg && cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end else if (pend_reg) begin
				pend_reg <= 1'b0;
				resp_valid <= 1'b1;
				resp_data <= poll_idx[3:0] ^ 4'h5;
				resp_err <= bad;
			end
		end
	end
endmodule

//--- tb/tb.sv
// Bench for the scan core: detections, polling, buffering, faults, auto addressing.
// Assumes shortened cycle-time parameters; ce drops once, while no slave is active.
`timescale 1ns/1ps
module tb;
	reg         clk, rst_b, power_ok_pin, auto_addr_en, flag_clr, det_valid, pcd_wr;
	reg         rx_ready, mute, bad, track, ab_seen, last_b, got_assign, ce;
	reg  [4:0]  det_addr;
	reg  [5:0]  pcd_idx, cfg_idx, watch;
	reg  [7:0]  dly;
	reg  [15:0] det_image, pcd_data;
	reg  [15:0] img_mem [0:31];
	wire        resp_valid, resp_err, poll_req, assign_req, addr_refused, rx_valid;
	wire        normal_operation_flag, power_fail, slave_fail, data_error;
	wire [3:0]  resp_data;
	wire [5:0]  poll_idx, assign_idx;
	wire [6:0]  active_count;
	wire [9:0]  rx_data;
	wire [15:0] detected_config_image, stored_config_expectation;
	integer     compares, miscompares, cyc, t_w, per, words, lk, i, r;
	asi_master_scan #(.CYC_BASE(20'h0012C), .CYC_SLOT(20'h00014), .CYC_MAX31(20'h00258),
		.CYC_MAX62(20'h004B0)) i_asi_master_scan (.ce(ce), .*);
	slave_model i_slave_model (.*);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function [15:0] exp_per(input integer n);
		exp_per = (n > 19) ? 16'h0014 * (n + 1) : 16'h012C;
		if (n <= 31 && exp_per > 16'h0258)
			exp_per = 16'h0258;
	endfunction
	task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task det(input [4:0] a, input [15:0] img, input refuse);
		det_addr = a;
		det_image = img;
		det_valid = 1'b1;
		@(negedge clk);
		det_valid = 1'b0;
		got_assign = assign_req;
		chk("refused", addr_refused, refuse);
		repeat (2) @(negedge clk);
	endtask
	task look(input [5:0] idx, input [15:0] d, input [15:0] s);
		cfg_idx = idx;
		repeat (2) @(negedge clk);
		chk("image", detected_config_image, d);
		chk("expectation", stored_config_expectation, s);
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (poll_req && poll_idx === watch) begin
			per = cyc - t_w;
			t_w = cyc;
		end
		if (rx_valid && rx_ready) begin
			words = words + 1;
			chk("rx data", rx_data[3:0], rx_data[7:4] ^ 4'h5);
			if (track) begin
				chk("order", {rx_data[8:4], rx_data[9]} > lk || rx_data[8:4] == 5'h01, 1);
				if (rx_data[8:4] == 5'h02 && ab_seen)
					chk("a b turn", rx_data[9], !last_b);
				if (rx_data[8:4] == 5'h02)
					{ab_seen, last_b} = {1'b1, rx_data[9]};
			end
			lk = {rx_data[8:4], rx_data[9]};
		end
	end
	initial begin
		{rst_b, power_ok_pin, auto_addr_en, flag_clr, det_valid, pcd_wr} = 6'h10;
		{rx_ready, mute, bad, track, ab_seen, last_b} = 6'h00;
		ce = 1'b1;
		{det_addr, det_image, pcd_idx, pcd_data, cfg_idx, watch} = 55'h0;
		{compares, miscompares, cyc, t_w, per, words, lk} = 0;
		r = $urandom(86302);
		dly = 8'h01 + 8'($urandom % 4);
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		det(5'h01, 16'h07F7, 1'b0);
		look(6'h01, 16'h07F7, 16'hFFFF);
		det(5'h01, 16'hA7F9, 1'b1);
		det(5'h02, 16'hA7F1, 1'b0);
		det(5'h02, 16'hA7F9, 1'b0);
		det(5'h02, 16'h07F7, 1'b1);
		det(5'h01, 16'h0177, 1'b1);
		det(5'h03, 16'h0F00, 1'b1);
		// Every defined allocation code 0h..Eh is accepted at least once among these.
		for (i = 4; i < 26; i = i + 1) begin
			img_mem[i] = {4'h0, 4'(i % 15), 8'($urandom)};
			det(i[4:0], img_mem[i], 1'b0);
		end
		chk("count", active_count, 16'h0019);
		chk("no power fail", power_fail, 16'h0000);
		pcd_idx = 6'h05;
		pcd_data = img_mem[5];
		pcd_wr = 1'b1;
		@(negedge clk);
		pcd_wr = 1'b0;
		look(6'h05, img_mem[5], img_mem[5]);
		watch = 6'h01;
		for (i = 0; i < 5000 && normal_operation_flag !== 1'b1; i = i + 1)
			@(negedge clk);
		chk("normal", normal_operation_flag, 16'h0001);
		if (normal_operation_flag !== 1'b1)
			end_sim;
		{rx_ready, track} = 2'h3;
		repeat (1600) @(negedge clk);
		chk("cycle", per, exp_per(25));
		rx_ready = 1'b0;
		repeat (1500) @(negedge clk);
		chk("full", rx_valid, 16'h0001);
		r = words;
		rx_ready = 1'b1;
		repeat (32) @(negedge clk);
		chk("drained", words - r, 16'h0020);
		// The reserved-code detection left data_error set; clear it so the next check means something.
		flag_clr = 1'b1;
		@(negedge clk);
		flag_clr = 1'b0;
		@(negedge clk);
		chk("cleared", data_error, 16'h0000);
		{track, bad} = 2'h1;
		repeat (600) @(negedge clk);
		chk("data error", data_error, 16'h0001);
		bad = 1'b0;
		// A corrupt reply already in flight would win over the clear, so let it land first.
		repeat (2) @(negedge clk);
		flag_clr = 1'b1;
		@(negedge clk);
		flag_clr = 1'b0;
		@(negedge clk);
		chk("cleared", data_error, 16'h0000);
		mute = 1'b1;
		repeat (3000) @(negedge clk);
		chk("slave fail", slave_fail, 16'h0001);
		chk("count", active_count, 16'h0000);
		look(6'h05, 16'hFFFF, img_mem[5]);
		mute = 1'b0;
		// With ce low the core must ignore a detection entirely.
		ce = 1'b0;
		det(5'h06, 16'h0123, 1'b0);
		ce = 1'b1;
		repeat (2) @(negedge clk);
		chk("frozen", active_count, 16'h0000);
		det(5'h00, img_mem[5], 1'b0);
		chk("assign", got_assign, 16'h0000);
		auto_addr_en = 1'b1;
		det(5'h00, img_mem[5], 1'b0);
		chk("assign", got_assign, 16'h0001);
		chk("assign idx", assign_idx, 16'h0005);
		det(5'h05, img_mem[5], 1'b0);
		watch = 6'h05;
		repeat (1000) @(negedge clk);
		chk("count", active_count, 16'h0001);
		chk("cycle", per, exp_per(1));
		power_ok_pin = 1'b0;
		repeat (8) @(negedge clk);
		chk("power fail", power_fail, 16'h0001);
		chk("normal", normal_operation_flag, 16'h0000);
		end_sim;
	end
endmodule
